// *** common/mfc_pkg.sv ***
/*
 Shared types and constants of the Manchester frame codec.
 Assumes a 100 MHz system clock and a 10 Mbit/s line.
*/
package mfc_pkg;
   // -------------------------------------------------------------
   // Line symbols, error codes and state encodings
   // -------------------------------------------------------------
   typedef enum logic [1:0] {SYM_ZERO = 2'h0, SYM_ONE = 2'h1, SYM_NPLUS = 2'h2, SYM_NMINUS = 2'h3} sym_type;
   typedef enum logic [1:0] {ERR_CODE = 2'h0, ERR_SLIP = 2'h1, ERR_ALIGN = 2'h2, ERR_OVERSIZE = 2'h3} err_type;
   typedef enum logic [2:0] {TX_IDLE = 3'h0, TX_SOF0 = 3'h1, TX_SOFN = 3'h3, TX_DATA = 3'h2,
                             TX_EOFN = 3'h6, TX_EOF0 = 3'h7, TX_GAP = 3'h5} tx_state_type;
   typedef enum logic [2:0] {RX_HUNT = 3'h0, RX_SOFZ = 3'h1, RX_FRAME = 3'h3, RX_EOFN = 3'h2,
                             RX_GAP = 3'h6} rx_state_type;
   // -------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------
   localparam int         CLK_PERIOD_NS = 10;
   localparam int         BIT_TIME_NS   = 100;
   localparam int         CLKS_PER_BIT  = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] PH_RESET      = 4'h0;
   localparam logic [3:0] PH_LAST       = 4'(CLKS_PER_BIT - 1);
   localparam logic [3:0] PH_HALF       = 4'(CLKS_PER_BIT / 2);
   localparam logic [3:0] PH_SAMPLE_A   = 4'(CLKS_PER_BIT / 4);
   localparam logic [3:0] PH_SAMPLE_B   = 4'(CLKS_PER_BIT / 2 + CLKS_PER_BIT / 4);
   localparam logic [3:0] PH_TOL        = 4'h1;
   // -------------------------------------------------------------
   // Frame limits
   // -------------------------------------------------------------
   localparam int          GAP_MIN_BITS  = 92;
   localparam int          MAX_OCTETS    = 1535;
   localparam int          BITCNT_W      = 14;
   localparam logic [13:0] MAX_BIT_COUNT = 14'(MAX_OCTETS * 8);
endpackage

// *** common/sym_if.sv ***
/*
 Symbol carrier between the codec core, the encoder and the decoder.
 Assumes all three sit on one clock.
*/
`timescale 1ns/1ps
interface sym_if;
   import mfc_pkg::*;
   sym_type tx_sym;    // Symbol for the next transmit cell
   logic    tx_frame;  // Next cell belongs to a frame
   logic    tx_take;   // Encoder loads tx_sym this cycle
   sym_type rx_sym;    // Last decoded cell
   logic    rx_valid;  // rx_sym new this cycle
   logic    rx_slip;   // Edge far from a half-bit position
   logic    rx_hunt;   // Receiver not in a frame
   modport core (output tx_sym, tx_frame, rx_hunt, input tx_take, rx_sym, rx_valid, rx_slip);
   modport enc  (input tx_sym, tx_frame, output tx_take);
   modport dec  (input rx_hunt, output rx_sym, rx_valid, rx_slip);
endinterface // sym_if

// *** design/manchester_tx_encoder.sv ***
/*
 Bit-cell timer and Manchester encoder for one symbol per cell.
 Assumes the core presents the next symbol whenever tx_take is high.
*/
`timescale 1ns/1ps
module manchester_tx_encoder
   import mfc_pkg::*;
(
   input  wire logic clk,        // System clock
   input  wire logic rst,        // Asynchronous reset, high
   sym_if.enc        lnk,        // Symbol carrier
   output logic      line,       // Encoded line level
   output logic      frame       // Line cell is part of a frame
);
   logic [3:0] ph;
   sym_type    cur;
   logic       cur_frame;
   wire        cell_end    = ph == PH_LAST;
   wire        first_high  = (cur == SYM_ONE) || (cur == SYM_NPLUS);
   wire        second_high = (cur == SYM_ZERO) || (cur == SYM_NPLUS);
   wire        next_line   = (ph < PH_HALF) ? first_high : second_high;
   assign lnk.tx_take = cell_end;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ph        <= PH_RESET;
         cur       <= SYM_ZERO;
         cur_frame <= 1'b0;
         line      <= 1'b0;
         frame     <= 1'b0;
      end else begin
         ph        <= cell_end ? PH_RESET : ph + 4'h1;
         cur       <= cell_end ? lnk.tx_sym : cur;
         cur_frame <= cell_end ? lnk.tx_frame : cur_frame;
         line      <= next_line;
         frame     <= cur_frame;
      end
   end
endmodule // manchester_tx_encoder

// *** design/manchester_rx_decoder.sv ***
/*
 Oversampling Manchester decoder: tracks half-bit edges, samples each
 half cell and reports one symbol per cell. Assumes a synchronised line.
*/
`timescale 1ns/1ps
module manchester_rx_decoder
   import mfc_pkg::*;
(
   input  wire logic clk,        // System clock
   input  wire logic rst,        // Asynchronous reset, high
   input  wire logic line,       // Synchronised line level
   sym_if.dec        lnk         // Symbol carrier
);
   logic [3:0] ph;
   logic       prev;
   logic       half_a;
   logic       half_b;
   // Nominal polarity only; an inverted pair simply decodes as other symbols
   wire        edge_seen  = line != prev;
   wire        near_bound = (ph <= PH_TOL) || (ph == PH_LAST);
   wire        near_mid   = (ph + PH_TOL >= PH_HALF) && (ph <= PH_HALF + PH_TOL);
   wire        cell_end   = ph == PH_LAST;
   wire        sym_type cell_sym = half_a ? (half_b ? SYM_NPLUS : SYM_ONE)
                                          : (half_b ? SYM_ZERO : SYM_NMINUS);
   // Idle is a run of zeros; reading ones while hunting means half a cell off
   wire        half_shift = cell_end && lnk.rx_hunt && (cell_sym == SYM_ONE);
   wire [3:0]  next_ph    = (edge_seen && near_bound) ? PH_TOL :
                            (edge_seen && near_mid)   ? PH_HALF + PH_TOL :
                            half_shift                ? PH_HALF :
                            cell_end                  ? PH_RESET : ph + 4'h1;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ph           <= PH_RESET;
         prev         <= 1'b0;
         half_a       <= 1'b0;
         half_b       <= 1'b0;
         lnk.rx_sym   <= SYM_ZERO;
         lnk.rx_valid <= 1'b0;
         lnk.rx_slip  <= 1'b0;
      end else begin
         ph           <= next_ph;
         prev         <= line;
         half_a       <= (ph == PH_SAMPLE_A) ? line : half_a;
         half_b       <= (ph == PH_SAMPLE_B) ? line : half_b;
         lnk.rx_sym   <= cell_end ? cell_sym : lnk.rx_sym;
         lnk.rx_valid <= cell_end;
         lnk.rx_slip  <= edge_seen && !near_bound && !near_mid;
      end
   end
endmodule // manchester_rx_decoder

// *** design/manchester_frame_codec.sv ***
/*
 Medium dependent sublayer for a twisted-pair Manchester fieldbus:
 frames link-layer bits with delimiters and idle, encodes them, and
 on receive decodes, strips framing and reports errors.
 Assumes a link interface sublayer on the same clock and a line
 attachment unit whose receive pin is asynchronous.
*/
// Contract
// - Transmit idle, start delimiter, data bits, end delimiter, idle, in order.
// - Receive strips idle and delimiters, forwards only data bits in order.
// - Non-data symbol inside data: stop forwarding, flag error, then end activity.
// - One is high then low; zero is low then high.
// - Positive non-data is high whole cell; negative is low whole cell.
// - Decode inversely and flag every invalid code pattern as an error.
// - End delimiter after a bit count not multiple of eight: alignment error.
// - Every receive error ends the frame with an error code.
// - No polarity detection; line always read with nominal polarity.
// - Start delimiter is zero then positive non-data; frame only after it.
// - End delimiter is negative non-data then zero, stripped on receive.
// - No end delimiter within 1535 octets: oversize error.
// - Send idle zeros, cell aligned, whenever nothing else is sent.
// - After start delimiter, report half-bit slip as an error.
// - Lock fast enough that at most four preamble bits are lost.
// - At least 92 idle bit times between transmitted frames.
// - Ignore the line for the same gap after a received frame.
// - Management may lengthen the gap, never shorten it below minimum.
`timescale 1ns/1ps
module manchester_frame_codec
   import mfc_pkg::*;
#(
   parameter int GAP_W = 8                        // Width of the gap setting
)
(
   input  wire logic             CLK_SYS,         // System clock, 100 MHz
   input  wire logic             RST,             // Asynchronous reset, high
   input  wire logic             TX_VALID,        // Link has a bit to send
   input  wire logic             TX_BIT,          // Bit to send
   input  wire logic             TX_LAST,         // Bit is the last of the frame
   output logic                  TX_TAKE,         // Bit taken, pulse
   input  wire logic [GAP_W-1:0] GAP_BITS,        // Requested gap in bit times
   output logic                  TX_LINE,         // Encoded line to transceiver
   output logic                  TX_EN,           // Transmit enable to transceiver
   output logic                  TX_BUSY,         // Frame or gap in progress
   input  wire logic             RX_LINE,         // Line from transceiver, async
   output logic                  RX_START,        // Start of activity, pulse
   output logic                  RX_BIT_VALID,    // Received bit, pulse
   output logic                  RX_BIT,          // Received bit value
   output logic                  RX_ERR,          // End with error, pulse
   output mfc_pkg::err_type      RX_ERR_CODE,     // Error code of last error
   output logic                  RX_END,          // End of activity, pulse
   output logic                  RX_ACTIVE        // Inside a received frame
);
   import mfc_pkg::*;

   // -------------------------------------------------------------
   // Shared gap setting
   // -------------------------------------------------------------
   localparam logic [GAP_W-1:0] GAP_MIN = GAP_W'(GAP_MIN_BITS);

   // A short request is raised to the minimum, never obeyed
   wire [GAP_W-1:0] gap_limit = (GAP_BITS < GAP_MIN) ? GAP_MIN : GAP_BITS;
   wire [GAP_W-1:0] gap_last  = gap_limit - GAP_W'(1);

   sym_if lnk ();

   // -------------------------------------------------------------
   // Encoder and decoder
   // -------------------------------------------------------------
   logic line_meta;
   logic line_sync;

   manchester_tx_encoder u_enc (
      .clk   (CLK_SYS),
      .rst   (RST),
      .lnk   (lnk.enc),
      .line  (TX_LINE),
      .frame (TX_EN)
   );

   manchester_rx_decoder u_dec (
      .clk   (CLK_SYS),
      .rst   (RST),
      .line  (line_sync),
      .lnk   (lnk.dec)
   );

   // Two stages before the decoder looks at the pin
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         line_meta <= 1'b0;
         line_sync <= 1'b0;
      end else begin
         line_meta <= RX_LINE;
         line_sync <= line_meta;
      end
   end

   // -------------------------------------------------------------
   // Transmit framing
   // -------------------------------------------------------------
   tx_state_type     tx_state;
   tx_state_type     next_tx_state;
   logic             tx_bit;
   logic             tx_last;
   logic [GAP_W-1:0] tx_gap_cnt;

   wire take      = lnk.tx_take;
   wire gap_done  = tx_gap_cnt >= gap_last;
   wire in_tx_gap = tx_state == TX_GAP;

   // Fetch the first bit during the start delimiter, later bits during data
   wire fetch = take && TX_VALID && ((tx_state == TX_SOFN) || ((tx_state == TX_DATA) && !tx_last));

   // Symbol handed to the encoder for the coming cell
   assign lnk.tx_sym = (tx_state == TX_SOFN) ? SYM_NPLUS :
                       (tx_state == TX_DATA) ? (tx_bit ? SYM_ONE : SYM_ZERO) :
                       (tx_state == TX_EOFN) ? SYM_NMINUS :
                       SYM_ZERO;

   assign lnk.tx_frame = (tx_state != TX_IDLE) && (tx_state != TX_GAP);

   always_comb begin
      next_tx_state = tx_state;
      unique case (tx_state)
         TX_IDLE: begin
            if (take && TX_VALID) begin
               next_tx_state = TX_SOF0;
            end
         end
         TX_SOF0: begin
            if (take) begin
               next_tx_state = TX_SOFN;
            end
         end
         TX_SOFN: begin
            if (take) begin
               next_tx_state = TX_VALID ? TX_DATA : TX_EOFN;
            end
         end
         TX_DATA: begin
            // An empty link side ends the frame cleanly rather than stalling the line
            if (take && (tx_last || !TX_VALID)) begin
               next_tx_state = TX_EOFN;
            end
         end
         TX_EOFN: begin
            if (take) begin
               next_tx_state = TX_EOF0;
            end
         end
         TX_EOF0: begin
            if (take) begin
               next_tx_state = TX_GAP;
            end
         end
         TX_GAP: begin
            if (take && gap_done) begin
               next_tx_state = TX_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         tx_state <= TX_IDLE;
         TX_BUSY  <= 1'b0;
      end else begin
         tx_state <= next_tx_state;
         TX_BUSY  <= next_tx_state != TX_IDLE;
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         tx_bit  <= 1'b0;
         tx_last <= 1'b0;
         TX_TAKE <= 1'b0;
      end else begin
         tx_bit  <= fetch ? TX_BIT : tx_bit;
         tx_last <= fetch ? TX_LAST : tx_last;
         TX_TAKE <= fetch;
      end
   end

   // Idle cells counted after the end delimiter
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         tx_gap_cnt <= '0;
      end else if (!in_tx_gap) begin
         tx_gap_cnt <= '0;
      end else if (take) begin
         tx_gap_cnt <= tx_gap_cnt + GAP_W'(1);
      end
   end

   // -------------------------------------------------------------
   // Receive framing
   // -------------------------------------------------------------
   rx_state_type        rx_state;
   rx_state_type        next_rx_state;
   logic [BITCNT_W-1:0] bit_cnt;
   logic [GAP_W-1:0]    rx_gap_cnt;
   logic                end_pend;
   err_type             next_err;

   wire     sym_v    = lnk.rx_valid;
   sym_type sym;
   assign   sym      = lnk.rx_sym;
   wire     in_frame = (rx_state == RX_FRAME) || (rx_state == RX_EOFN);
   wire     data_sym = (sym == SYM_ZERO) || (sym == SYM_ONE);
   wire     in_rgap  = rx_state == RX_GAP;

   assign lnk.rx_hunt = !in_frame;

   // Frame events
   wire sof_hit      = (rx_state == RX_SOFZ) && sym_v && (sym == SYM_NPLUS);
   wire slip_hit     = in_frame && lnk.rx_slip;
   wire oversize_hit = (rx_state == RX_FRAME) && sym_v && data_sym
                       && (bit_cnt == MAX_BIT_COUNT);
   wire code_hit     = sym_v && (((rx_state == RX_FRAME) && (sym == SYM_NPLUS))
                       || ((rx_state == RX_EOFN) && (sym != SYM_ZERO)));
   wire eof_hit      = (rx_state == RX_EOFN) && sym_v && (sym == SYM_ZERO);
   wire align_hit    = eof_hit && (bit_cnt[2:0] != 3'h0);
   wire err_hit      = slip_hit || code_hit || oversize_hit || align_hit;
   wire good_end     = eof_hit && !err_hit;
   wire bit_take     = (rx_state == RX_FRAME) && sym_v && data_sym && !err_hit;
   wire rgap_done    = rx_gap_cnt >= gap_last;

   // Slip outranks the others: a slipped cell makes any code check meaningless
   assign next_err = slip_hit     ? ERR_SLIP :
                     code_hit     ? ERR_CODE :
                     oversize_hit ? ERR_OVERSIZE :
                     ERR_ALIGN;

   always_comb begin
      next_rx_state = rx_state;
      unique case (rx_state)
         RX_HUNT: begin
            if (sym_v && (sym == SYM_ZERO)) begin
               next_rx_state = RX_SOFZ;
            end
         end
         RX_SOFZ: begin
            if (sof_hit) begin
               next_rx_state = RX_FRAME;
            end else if (sym_v && (sym != SYM_ZERO)) begin
               next_rx_state = RX_HUNT;
            end
         end
         RX_FRAME: begin
            if (err_hit) begin
               next_rx_state = RX_GAP;
            end else if (sym_v && (sym == SYM_NMINUS)) begin
               next_rx_state = RX_EOFN;
            end
         end
         RX_EOFN: begin
            if (err_hit || good_end) begin
               next_rx_state = RX_GAP;
            end
         end
         RX_GAP: begin
            if (sym_v && rgap_done) begin
               next_rx_state = RX_HUNT;
            end
         end
      endcase
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         rx_state  <= RX_HUNT;
         RX_ACTIVE <= 1'b0;
      end else begin
         rx_state  <= next_rx_state;
         RX_ACTIVE <= (next_rx_state == RX_FRAME) || (next_rx_state == RX_EOFN);
      end
   end

   // Bit count from the end of the start delimiter
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         bit_cnt <= '0;
      end else if (sof_hit) begin
         bit_cnt <= '0;
      end else if (bit_take) begin
         bit_cnt <= bit_cnt + BITCNT_W'(1);
      end
   end

   // Line ignored for the gap, measured in received cells
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         rx_gap_cnt <= '0;
      end else if (!in_rgap) begin
         rx_gap_cnt <= '0;
      end else if (sym_v) begin
         rx_gap_cnt <= rx_gap_cnt + GAP_W'(1);
      end
   end

   // -------------------------------------------------------------
   // Receive indications
   // -------------------------------------------------------------
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         RX_START     <= 1'b0;
         RX_BIT_VALID <= 1'b0;
         RX_BIT       <= 1'b0;
      end else begin
         RX_START     <= sof_hit;
         RX_BIT_VALID <= bit_take;
         RX_BIT       <= bit_take ? (sym == SYM_ONE) : RX_BIT;
      end
   end

   // Error first, end of activity one cycle later
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         RX_ERR      <= 1'b0;
         RX_ERR_CODE <= ERR_CODE;
         end_pend    <= 1'b0;
         RX_END      <= 1'b0;
      end else begin
         RX_ERR      <= err_hit;
         RX_ERR_CODE <= err_hit ? next_err : RX_ERR_CODE;
         end_pend    <= err_hit;
         RX_END      <= good_end || end_pend;
      end
   end

endmodule // manchester_frame_codec

// *** dv/mfc_checker.sv ***
/*
 Port-level assertions for the Manchester frame codec.
 Assumes one 100 MHz clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
module mfc_checker
   import mfc_pkg::*;
#(
   parameter int GAP_W = 8                        // Width of the gap setting
)
(
   input wire logic             CLK_SYS,          // Clock
   input wire logic             RST,              // Reset
   input wire logic             TX_VALID,         // Bit ready
   input wire logic             TX_BIT,           // Bit value
   input wire logic             TX_LAST,          // Last bit
   input wire logic             TX_TAKE,          // Bit taken
   input wire logic [GAP_W-1:0] GAP_BITS,         // Gap setting
   input wire logic             TX_LINE,          // Encoded line
   input wire logic             TX_EN,            // Transmit enable
   input wire logic             TX_BUSY,          // Frame or gap
   input wire logic             RX_LINE,          // Receive line
   input wire logic             RX_START,         // Frame start
   input wire logic             RX_BIT_VALID,     // Bit strobe
   input wire logic             RX_BIT,           // Bit value
   input wire logic             RX_ERR,           // Error strobe
   input wire mfc_pkg::err_type RX_ERR_CODE,      // Error code
   input wire logic             RX_END,           // End strobe
   input wire logic             RX_ACTIVE         // In frame
);
   // -------------------------------------------------------------
   // Helpers: constant-level run and idle span
   // -------------------------------------------------------------
   logic [4:0]  run;
   logic        prev;
   logic [10:0] gap;
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         run  <= 5'h0;
         prev <= 1'b0;
         gap  <= 11'h7FF;
      end else begin
         run  <= (TX_LINE == prev) ? ((run == 5'h1F) ? run : run + 5'h1) : 5'h0;
         prev <= TX_LINE;
         gap  <= TX_EN ? 11'h0 : ((gap == 11'h7FF) ? gap : gap + 11'h1);
      end
   end
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   a_take_spacing: assert property (TX_TAKE |=> !TX_TAKE [*8]) else $error("bit taken too soon");
   // Longest legal level: ZERO, N+, then ONE gives four halves high
   a_line_run: assert property (run <= 5'd19) else $error("line level held too long");
   a_idle_zero: assert property (!TX_EN && $rose(TX_LINE) |-> TX_LINE [*5] ##1 !TX_LINE)
      else $error("idle cell not a zero");
   a_gap_min: assert property ($rose(TX_EN) |-> gap >= 11'd920) else $error("gap too short");
   a_en_busy: assert property (TX_EN |-> TX_BUSY) else $error("enable without busy");
   a_err_end: assert property (RX_ERR |=> RX_END) else $error("no end after error");
   a_start_act: assert property (RX_START |=> RX_ACTIVE) else $error("start without activity");
   a_bit_act: assert property (RX_BIT_VALID |-> RX_ACTIVE) else $error("bit outside frame");
   a_end_idle: assert property (RX_END |=> !RX_ACTIVE && !RX_BIT_VALID) else $error("activity after end");
endmodule // mfc_checker

bind manchester_frame_codec mfc_checker #(.GAP_W(GAP_W)) mfc_checker_i (
   .CLK_SYS(CLK_SYS), .RST(RST), .TX_VALID(TX_VALID), .TX_BIT(TX_BIT), .TX_LAST(TX_LAST),
   .TX_TAKE(TX_TAKE), .GAP_BITS(GAP_BITS), .TX_LINE(TX_LINE), .TX_EN(TX_EN), .TX_BUSY(TX_BUSY),
   .RX_LINE(RX_LINE), .RX_START(RX_START), .RX_BIT_VALID(RX_BIT_VALID), .RX_BIT(RX_BIT),
   .RX_ERR(RX_ERR), .RX_ERR_CODE(RX_ERR_CODE), .RX_END(RX_END), .RX_ACTIVE(RX_ACTIVE));

// *** dv/line_xcvr_model.sv ***
/*
 Behavioural line transceiver: plays queued cells onto the receive line.
 Assumes 10 clocks per cell; cell codes are {first half, second half}.
*/
`timescale 1ns/1ps
module line_xcvr_model (
   input  wire logic clk,                         // System clock
   output logic      line                         // Receive line to the codec
);
   logic [1:0] q[$];
   logic [1:0] cur;
   int         ph;
   task automatic send(input logic [1:0] s);
      q.push_back(s);
   endtask
   initial begin
      line = 1'b0;
      cur  = 2'b01;
      ph   = 0;
   end
   // Idle cells are ZERO so the receiver stays locked between frames
   always @(negedge clk) begin
      if (ph == 0)
         cur = (q.size() != 0) ? q.pop_front() : 2'b01;
      line <= (ph < 5) ? cur[1] : cur[0];
      ph = (ph == 9) ? 0 : ph + 1;
   end
endmodule // line_xcvr_model

// *** dv/testbench.sv ***
/*
 Self-checking bench for the Manchester frame codec.
 Assumes the transceiver model above and a 100 MHz clock.
*/
`timescale 1ns/1ps
module testbench;
   import mfc_pkg::*;
   logic CLK_SYS, RST, tx_valid, tx_bit, tx_last, take, tx_line, tx_en, rx_line;
   logic [7:0] gap_bits;
   logic rx_start, rx_valid, rx_bit, rx_err, rx_end;
   err_type code, rx_code;
   logic [15:0] rx_bits;
   logic rx_st, rx_e, rx_fin;
   int rx_n, n_errors, check_count;
   manchester_frame_codec manchester_frame_codec_i (.CLK_SYS(CLK_SYS), .RST(RST), .TX_VALID(tx_valid),
      .TX_BIT(tx_bit), .TX_LAST(tx_last), .TX_TAKE(take), .GAP_BITS(gap_bits), .TX_LINE(tx_line),
      .TX_EN(tx_en), .TX_BUSY(), .RX_LINE(rx_line), .RX_START(rx_start), .RX_BIT_VALID(rx_valid),
      .RX_BIT(rx_bit), .RX_ERR(rx_err), .RX_ERR_CODE(code), .RX_END(rx_end), .RX_ACTIVE());
   line_xcvr_model line_xcvr_model_i (.clk(CLK_SYS), .line(rx_line));
   initial begin
      CLK_SYS = 1'b0;
      forever #5 CLK_SYS = ~CLK_SYS;
   end
   always @(posedge CLK_SYS) begin
      if (rx_valid === 1'b1) begin
         rx_bits = {rx_bits[14:0], rx_bit};
         rx_n++;
      end
      if (rx_start === 1'b1) rx_st = 1'b1;
      if (rx_end === 1'b1) rx_fin = 1'b1;
      if (rx_err === 1'b1) begin
         rx_e = 1'b1;
         rx_code = code;
      end
   end
   task automatic chk(input logic ok, input string msg);
      check_count++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic send_frame(input logic [15:0] b, input int n);
      int k;
      @(negedge CLK_SYS);
      for (int i = n - 1; i >= 0; i--) begin
         tx_valid = 1'b1;
         tx_bit = b[i];
         tx_last = (i == 0);
         k = 0;
         do begin @(negedge CLK_SYS); k++; end while (take !== 1'b1 && k < 3000);
         chk(k < 3000, "bit not taken");
      end
      tx_valid = 1'b0;
      tx_last = 1'b0;
   endtask
   // Sample each cell 1.5 clocks into both halves
   task automatic t_tx_frame;
      logic [7:0] b;
      logic [1:0] s, x;
      b = 8'hB4;
      fork
         send_frame({8'h00, b}, 8);
         begin
            @(posedge tx_en);
            for (int k = 0; k < 13; k++) begin
               repeat (2) @(negedge CLK_SYS);
               s[1] = tx_line;
               repeat (5) @(negedge CLK_SYS);
               s[0] = tx_line;
               x = (k == 0) ? 2'b01 : (k == 1) ? 2'b11 : (k < 10) ? {b[9-k], ~b[9-k]} : (k == 10) ? 2'b00 : 2'b01;
               chk(s === x, "line symbol");
               chk(tx_en === (k < 12), "transmit enable");
               repeat (3) @(negedge CLK_SYS);
            end
         end
      join
      $display("tx frame done");
   endtask
   task automatic t_gap(input logic [7:0] g, input int lo);
      int c;
      gap_bits = g;
      c = 0;
      fork
         begin send_frame(16'h0001, 1); send_frame(16'h0000, 1); end
         begin
            @(negedge tx_en);
            while (tx_en !== 1'b1 && c < 3000) begin @(posedge CLK_SYS); c++; end
         end
      join
      chk(c >= lo && c <= lo + 40, "gap length");
      $display("gap %0d done", g);
   endtask
   task automatic rx_run(input logic [15:0] b, input int n, input logic [1:0] t0, t1,
                         input logic xe, input err_type xc);
      int k;
      rx_n = 0;
      rx_bits = 16'h0000;
      rx_st = 1'b0;
      rx_e = 1'b0;
      rx_fin = 1'b0;
      line_xcvr_model_i.send(2'b01);
      line_xcvr_model_i.send(2'b11);
      for (int i = n - 1; i >= 0; i--) line_xcvr_model_i.send(b[i] ? 2'b10 : 2'b01);
      line_xcvr_model_i.send(t0);
      line_xcvr_model_i.send(t1);
      k = 0;
      while (rx_fin !== 1'b1 && k < 3000) begin @(posedge CLK_SYS); k++; end
      chk(rx_st === 1'b1 && rx_fin === 1'b1, "start or end missing");
      chk(rx_n == n && rx_bits === b, "received bits");
      chk(rx_e === xe && (!xe || rx_code === xc), "error report");
      // Outlasts the longest receive gap (0x78 cells) so the next start delimiter is heard
      repeat (1300) @(posedge CLK_SYS);
   endtask
   task automatic t_rx_good;
      rx_run(16'h00C5, 8, 2'b00, 2'b01, 1'b0, ERR_CODE);
      $display("rx good done");
   endtask
   task automatic t_rx_align;
      rx_run(16'h0016, 5, 2'b00, 2'b01, 1'b1, ERR_ALIGN);
      $display("rx align done");
   endtask
   task automatic t_rx_code;
      rx_run(16'h0005, 3, 2'b11, 2'b01, 1'b1, ERR_CODE);
      $display("rx code done");
   endtask
   initial begin
      repeat (20000) @(posedge CLK_SYS);
      n_errors++;
      conclude;
   end
   initial begin
      RST = 1'b1;
      {tx_valid, tx_bit, tx_last} = 3'h0;
      gap_bits = 8'h00;
      {n_errors, check_count, rx_n} = '0;
      repeat (2) @(negedge CLK_SYS);
      RST = 1'b0;
      t_tx_frame();
      t_gap(8'h0A, 920);
      t_gap(8'h78, 1200);
      t_rx_good();
      t_rx_align();
      t_rx_code();
      conclude;
   end
endmodule // testbench
